/* shared/cs_map.svh */
// offsets, field positions, reset values and counts of the chip-select unit
`ifndef CS_MAP_SVH
`define CS_MAP_SVH
`define CS_NUM_BANKS 8
`define CS_SEL_BASE 2'h0
`define CS_SEL_MASK 2'h1
`define CS_SEL_CTRL 2'h2
`define CS_ADDR_HI 31
`define CS_ADDR_LO 16
`define CS_MASK_VALID 0
`define CS_MASK_CPU 6
`define CS_MASK_WP 8
`define CS_CTRL_WS_LSB 10
`define CS_CTRL_AA 8
`define CS_CTRL_PW_LSB 6
`define CS_CTRL_MODE 5
`define CS_CTRL_RBURST 4
`define CS_CTRL_WBURST 3
`define CS_RST_BASE 32'h0000_0000
`define CS_RST_MASK 32'h0000_0000
`define CS_RST_CTRL 32'h0000_0000
`define CS_BOOT_WS 4'hF
`define CS_STRAP_AA 7
`define CS_STRAP_PW_LSB 5
`define CS_STRAP_MODE 3
`define CS_LANES_OFF 4'hF
`define CS_SEL_NONE 8'hFF
`endif

/* shared/cs_pkg.sv */
// types shared by the chip-select unit
package cs_pkg;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_HOLD = 2'b11
  } cyc_state_e;
  typedef enum logic [1:0] {
    SZ_LONG = 2'b00,
    SZ_BYTE = 2'b01,
    SZ_WORD = 2'b10,
    SZ_LINE = 2'b11
  } xfer_size_e;
  typedef enum logic [1:0] {
    PW_32 = 2'b00,
    PW_8 = 2'b01,
    PW_16 = 2'b10
  } port_width_e;

  // both 1x codes mean a 16-bit port
  function automatic port_width_e pw_decode(input logic [1:0] code);
    if (code == 2'b00) begin
      return PW_32;
    end else if (code == 2'b01) begin
      return PW_8;
    end else begin
      return PW_16;
    end
  endfunction : pw_decode
endpackage : cs_pkg

/* shared/bank_cfg_if.sv */
// one bank's configuration and its address compare result
`timescale 1ns/1ps
interface bank_cfg_if;
  logic [31:0] base;
  logic [31:0] mask;
  logic [31:0] addr;
  logic cpu_space;
  logic rd;
  logic hit;
  modport owner(output base, mask, addr, cpu_space, rd, input hit);
  modport cmp(input base, mask, addr, cpu_space, rd, output hit);
endinterface : bank_cfg_if

/* logic/bank_match.sv */
// address and attribute compare for one bank
`timescale 1ns/1ps
`include "cs_map.svh"
module bank_match (
  bank_cfg_if.cmp bus
);
  logic [15:0] diff;
  always_comb begin
    diff = (bus.addr[`CS_ADDR_HI:`CS_ADDR_LO] ^
            bus.base[`CS_ADDR_HI:`CS_ADDR_LO]) &
           ~bus.mask[`CS_ADDR_HI:`CS_ADDR_LO];
    // cpu-space cycles match unless masked out; protected banks refuse writes
    bus.hit = bus.mask[`CS_MASK_VALID] && (diff == 16'h0000) &&
              !(bus.cpu_space && bus.mask[`CS_MASK_CPU]) &&
              !(!bus.rd && bus.mask[`CS_MASK_WP]);
  end
endmodule : bank_match

/* logic/lane_decode.sv */
// active-low byte-lane pattern from size, low address and port width
`timescale 1ns/1ps
module lane_decode (
  input cs_pkg::xfer_size_e size,
  input cs_pkg::port_width_e width,
  input wire logic [1:0] addr_lo,
  input wire logic burst,
  output logic [3:0] lanes_n
);
  import cs_pkg::*;
  xfer_size_e eff;
  always_comb begin
    // a line to a non-burst bank runs as single longwords
    eff = (size == SZ_LINE && !burst) ? SZ_LONG : size;
    // bit 0 drives the top byte lane, so an 8-bit port uses bit 0 only
    lanes_n = 4'hE;
    if (width == PW_16) begin
      if (eff == SZ_BYTE) begin
        lanes_n = addr_lo[0] ? 4'hD : 4'hE;
      end else begin
        lanes_n = 4'hC;
      end
    end else if (width == PW_32) begin
      if (eff == SZ_BYTE) begin
        lanes_n = ~(4'h1 << addr_lo);
      end else if (eff == SZ_WORD) begin
        lanes_n = addr_lo[1] ? 4'h3 : 4'hC;
      end else begin
        lanes_n = 4'h0;
      end
    end
  end
endmodule : lane_decode

/* logic/chip_select_byte_lane_decode.sv */
// chip-select unit: bank decode, boot select, output enable, lane strobes
`timescale 1ns/1ps
`include "cs_map.svh"
module chip_select_byte_lane_decode (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reset_input_n,
  input wire logic [7:0] strap_data,
  input wire logic cfg_wr,
  input wire logic [2:0] cfg_bank,
  input wire logic [1:0] cfg_sel,
  input wire logic [31:0] cfg_wdata,
  output logic [31:0] cfg_rdata,
  input wire logic cyc_start,
  input wire logic [31:0] cyc_addr,
  input cs_pkg::xfer_size_e cyc_size,
  input wire logic cyc_read,
  input wire logic cyc_cpu_space,
  input wire logic cyc_end,
  output logic boot_bank_select_n,
  output logic [7:1] bank_select_n,
  output logic output_enable_n,
  output logic [3:0] lane_strobe_n,
  output cs_pkg::port_width_e cyc_port_width,
  output logic cyc_burst_ok,
  output logic cyc_ext_term,
  output logic auto_ack,
  output logic boot_global
);
  import cs_pkg::*;

  logic [31:0] bank_base_reg [`CS_NUM_BANKS];
  logic [31:0] bank_mask_reg [`CS_NUM_BANKS];
  logic [31:0] bank_control_reg [`CS_NUM_BANKS];
  logic rst_pin_r;
  logic strap_rel;
  logic [31:0] boot_ctrl;
  logic [7:0] hit_v;
  logic [7:0] sel_nxt;
  logic multi;
  logic single;
  logic [2:0] idx;
  logic [31:0] ctrl_eff;
  port_width_e pw_eff;
  logic mode_eff;
  logic burst_eff;
  logic aa_eff;
  logic [3:0] ws_eff;
  logic [3:0] lane_pat;
  logic [3:0] lanes_nxt;
  cyc_state_e state_r;
  logic [3:0] ws_cnt_r;
  logic aa_r;
  logic rd_r;
  logic [7:0] csn_r;
  logic [3:0] lanes_r;
  logic oe_n_r;
  logic oe_want;
  logic ack_r;
  logic [31:0] rdata_r;
  port_width_e pw_r;
  logic burst_r;
  logic ext_term_r;
  logic start_ok;

  assign start_ok = cyc_start && (state_r == ST_IDLE);

  // catch the release edge of the reset pin
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_pin_r <= 1'b0;
    end else begin
      rst_pin_r <= reset_input_n;
    end
  end
  assign strap_rel = reset_input_n && !rst_pin_r;

  // width code kept raw, decoded with pw_decode when used
  always_comb begin
    boot_ctrl = `CS_RST_CTRL;
    boot_ctrl[`CS_CTRL_AA] = strap_data[`CS_STRAP_AA];
    boot_ctrl[`CS_CTRL_WS_LSB +: 4] =
      strap_data[`CS_STRAP_AA] ? `CS_BOOT_WS : 4'h0;
    boot_ctrl[`CS_CTRL_PW_LSB +: 2] = strap_data[`CS_STRAP_PW_LSB +: 2];
    boot_ctrl[`CS_CTRL_MODE] = strap_data[`CS_STRAP_MODE];
  end

  // three registers per bank; bank zero takes the straps
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int i = 0; i < `CS_NUM_BANKS; i++) begin
        bank_base_reg[i] <= `CS_RST_BASE;
        bank_mask_reg[i] <= `CS_RST_MASK;
        bank_control_reg[i] <= `CS_RST_CTRL;
      end
    end else begin
      if (cfg_wr) begin
        if (cfg_sel == `CS_SEL_BASE) begin
          bank_base_reg[cfg_bank] <= cfg_wdata;
        end else if (cfg_sel == `CS_SEL_MASK) begin
          bank_mask_reg[cfg_bank] <= cfg_wdata;
        end else if (cfg_sel == `CS_SEL_CTRL) begin
          bank_control_reg[cfg_bank] <= cfg_wdata;
        end
      end
      // strap capture wins over a software write in the same cycle
      if (strap_rel) begin
        bank_control_reg[0] <= boot_ctrl;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rdata_r <= 32'h0000_0000;
    end else if (cfg_sel == `CS_SEL_BASE) begin
      rdata_r <= bank_base_reg[cfg_bank];
    end else if (cfg_sel == `CS_SEL_MASK) begin
      rdata_r <= bank_mask_reg[cfg_bank];
    end else if (cfg_sel == `CS_SEL_CTRL) begin
      rdata_r <= bank_control_reg[cfg_bank];
    end else begin
      rdata_r <= 32'h0000_0000;
    end
  end

  // compare on the cycle's own attributes, any master
  bank_cfg_if bank_if [`CS_NUM_BANKS] ();
  for (genvar g = 0; g < `CS_NUM_BANKS; g++) begin : g_bank
    assign bank_if[g].base = bank_base_reg[g];
    assign bank_if[g].mask = bank_mask_reg[g];
    assign bank_if[g].addr = cyc_addr;
    assign bank_if[g].cpu_space = cyc_cpu_space;
    assign bank_if[g].rd = cyc_read;
    assign hit_v[g] = bank_if[g].hit;
    bank_match u_match (
      .bus(bank_if[g])
    );
  end

  // until bank zero is valid it answers every access alone
  assign boot_global = !bank_mask_reg[0][`CS_MASK_VALID];
  assign sel_nxt = boot_global ? 8'h01 : hit_v;
  assign multi = (sel_nxt & (sel_nxt - 8'h01)) != 8'h00;
  assign single = (sel_nxt != 8'h00) && !multi;

  always_comb begin
    idx = 3'h0;
    for (int i = `CS_NUM_BANKS - 1; i >= 0; i--) begin
      if (sel_nxt[i]) begin
        idx = 3'(i);
      end
    end
  end

  // one matching bank uses its own setup; else 32-bit external
  always_comb begin
    ctrl_eff = bank_control_reg[idx];
    if (single) begin
      pw_eff = pw_decode(ctrl_eff[`CS_CTRL_PW_LSB +: 2]);
      mode_eff = ctrl_eff[`CS_CTRL_MODE];
      burst_eff = cyc_read ? ctrl_eff[`CS_CTRL_RBURST] :
                             ctrl_eff[`CS_CTRL_WBURST];
      aa_eff = ctrl_eff[`CS_CTRL_AA];
      ws_eff = ctrl_eff[`CS_CTRL_WS_LSB +: 4];
    end else begin
      pw_eff = PW_32;
      mode_eff = 1'b0;
      burst_eff = 1'b0;
      aa_eff = 1'b0;
      ws_eff = 4'h0;
    end
  end

  lane_decode u_lanes (
    .size(cyc_size),
    .width(pw_eff),
    .addr_lo(cyc_addr[1:0]),
    .burst(burst_eff),
    .lanes_n(lane_pat)
  );

  // mode 0 keeps the lanes off during reads
  assign lanes_nxt = (!cyc_read || mode_eff) ? lane_pat : `CS_LANES_OFF;

  // wait states count before an internal acknowledge
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= ST_IDLE;
      ws_cnt_r <= 4'h0;
      aa_r <= 1'b0;
      rd_r <= 1'b0;
    end else if (state_r != ST_IDLE && cyc_end) begin
      state_r <= ST_IDLE;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (cyc_start) begin
            state_r <= ST_WAIT;
            ws_cnt_r <= ws_eff;
            aa_r <= aa_eff;
            rd_r <= cyc_read;
          end
        end
        ST_WAIT: begin
          if (ws_cnt_r == 4'h0) begin
            state_r <= ST_HOLD;
          end else begin
            ws_cnt_r <= ws_cnt_r - 4'h1;
          end
        end
        default: begin
          state_r <= ST_HOLD;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (state_r == ST_WAIT) && (ws_cnt_r == 4'h0) && aa_r &&
               !cyc_end;
    end
  end

  // selects and lanes held for the cycle, dropped at its end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      csn_r <= `CS_SEL_NONE;
      lanes_r <= `CS_LANES_OFF;
    end else if (state_r != ST_IDLE && cyc_end) begin
      csn_r <= `CS_SEL_NONE;
      lanes_r <= `CS_LANES_OFF;
    end else if (start_ok) begin
      csn_r <= ~sel_nxt;
      lanes_r <= lanes_nxt;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pw_r <= PW_32;
      burst_r <= 1'b0;
      ext_term_r <= 1'b1;
    end else if (start_ok) begin
      pw_r <= pw_eff;
      burst_r <= burst_eff;
      ext_term_r <= !aa_eff;
    end
  end

  // read strobe needs a live cycle and a matched bank
  assign oe_want = (state_r != ST_IDLE) && rd_r && (csn_r != `CS_SEL_NONE);

  // half a clock after the select, so it never leads it
  always_ff @(negedge clk or negedge nrst) begin
    if (!nrst) begin
      oe_n_r <= 1'b1;
    end else begin
      oe_n_r <= !oe_want;
    end
  end

  assign boot_bank_select_n = csn_r[0];
  assign bank_select_n = csn_r[7:1];
  assign output_enable_n = oe_n_r;
  assign lane_strobe_n = lanes_r;
  assign cyc_port_width = pw_r;
  assign cyc_burst_ok = burst_r;
  assign cyc_ext_term = ext_term_r;
  assign auto_ack = ack_r;
  assign cfg_rdata = rdata_r;

  sequence quick_ack_start_s;
    start_ok && single && aa_eff && (ws_eff == 4'h0);
  endsequence

  sequence no_end_s;
    !cyc_end ##1 !cyc_end;
  endsequence

  oe_follows_want_a: assert property (
    @(negedge clk) disable iff (!nrst)
    output_enable_n == !$past(oe_want))
    else $error("output enable did not follow on the falling edge");

  oe_needs_match_a: assert property (
    @(posedge clk) disable iff (!nrst)
    $fell(output_enable_n) |-> (csn_r != `CS_SEL_NONE) && rd_r)
    else $error("output enable asserted without a matched read");

  boot_global_sel_a: assert property (
    @(posedge clk) disable iff (!nrst)
    start_ok && boot_global |=> !boot_bank_select_n && (&bank_select_n))
    else $error("boot select not alone while global");

  read_lanes_off_a: assert property (
    @(posedge clk) disable iff (!nrst)
    start_ok && cyc_read && !mode_eff |=> lane_strobe_n == `CS_LANES_OFF)
    else $error("lane strobes active on read in write-only mode");

  long_lanes_all_a: assert property (
    @(posedge clk) disable iff (!nrst)
    start_ok && single && !cyc_read && pw_eff == PW_32 &&
    cyc_size == SZ_LONG |=> lane_strobe_n == 4'h0)
    else $error("32-bit longword write did not drive all lanes");

  select_end_a: assert property (
    @(posedge clk) disable iff (!nrst)
    state_r != ST_IDLE && cyc_end |=> csn_r == `CS_SEL_NONE &&
    lane_strobe_n == `CS_LANES_OFF)
    else $error("selects still active after cycle end");

  strap_width_a: assert property (
    @(posedge clk) disable iff (!nrst)
    strap_rel |=> bank_control_reg[0][`CS_CTRL_PW_LSB +: 2] ==
    $past(strap_data[`CS_STRAP_PW_LSB +: 2]))
    else $error("boot width not taken from straps");

  quick_ack_a: assert property (
    @(posedge clk) disable iff (!nrst)
    quick_ack_start_s ##0 no_end_s |=> auto_ack)
    else $error("zero-wait internal acknowledge missing");

  multi_default_a: assert property (
    @(posedge clk) disable iff (!nrst)
    start_ok && multi |=> cyc_port_width == PW_32 && cyc_ext_term &&
    !cyc_burst_ok)
    else $error("multiple match not run as plain 32-bit external");
endmodule : chip_select_byte_lane_decode

/* bench/ext_board.sv */
// board side: boot strap levels and external cycle termination
`timescale 1ns/1ps
module ext_board (
  input wire logic clk,
  input wire logic nrst,
  input wire logic reset_input_n,
  input wire logic [7:0] strap_cfg,
  input wire logic cyc_start,
  input wire logic [7:0] term_wait,
  output logic [7:0] strap_data,
  output logic cyc_end
);
  logic [7:0] last_r;
  logic [7:0] cnt_r;
  logic pin_r;
  logic busy_r;

  // straps held through the releasing edge
  // released bus shows inverted levels so a late sample cannot pass
  assign strap_data = (reset_input_n && pin_r) ? ~last_r : strap_cfg;

  always_ff @(posedge clk) begin
    pin_r <= reset_input_n;
    if (!(reset_input_n && pin_r)) begin
      last_r <= strap_cfg;
    end
  end

  // outside party ends each cycle after its wait
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      busy_r <= 1'b0;
      cnt_r <= 8'h00;
      cyc_end <= 1'b0;
    end else begin
      cyc_end <= 1'b0;
      if (cyc_start && !busy_r) begin
        busy_r <= 1'b1;
        cnt_r <= 8'h00;
      end else if (busy_r) begin
        cnt_r <= cnt_r + 8'h01;
        if (cnt_r == term_wait) begin
          cyc_end <= 1'b1;
          busy_r <= 1'b0;
        end
      end
    end
  end
endmodule : ext_board

/* bench/chip_select_byte_lane_decode_test.sv */
// self-checking bench of the chip-select unit
`timescale 1ns/1ps
module chip_select_byte_lane_decode_test;
  import cs_pkg::*;
  logic clk, nrst, reset_input_n, cfg_wr, cyc_start, cyc_read, cyc_end;
  logic cyc_cpu_space, boot_bank_select_n, output_enable_n, auto_ack;
  logic cyc_burst_ok, cyc_ext_term, boot_global;
  logic [7:0] strap_data, strap_cfg, e_sel, term_wait;
  logic [2:0] cfg_bank;
  logic [1:0] cfg_sel;
  logic [31:0] cfg_wdata, cfg_rdata, cyc_addr, rv;
  logic [7:1] bank_select_n;
  logic [3:0] lane_strobe_n;
  xfer_size_e cyc_size;
  port_width_e cyc_port_width;
  int fails, check_count, e_pw, e_mode, e_ack, e_burst;

  chip_select_byte_lane_decode i_chip_select_byte_lane_decode (.clk, .nrst,
    .reset_input_n, .strap_data, .cfg_wr, .cfg_bank, .cfg_sel, .cfg_wdata,
    .cfg_rdata, .cyc_start, .cyc_addr, .cyc_size, .cyc_read, .cyc_cpu_space,
    .cyc_end, .boot_bank_select_n, .bank_select_n, .output_enable_n,
    .lane_strobe_n, .cyc_port_width, .cyc_burst_ok, .cyc_ext_term,
    .auto_ack, .boot_global);
  ext_board i_ext_board (.clk, .nrst, .reset_input_n, .strap_cfg,
    .cyc_start, .term_wait, .strap_data, .cyc_end);

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, fails);
    if (fails == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : end_sim

  task automatic wr(input int b, input int s, input logic [31:0] d);
    @(posedge clk);
    cfg_wr <= 1'b1;
    cfg_bank <= b[2:0];
    cfg_sel <= s[1:0];
    cfg_wdata <= d;
    @(posedge clk);
    cfg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input int b, input int s);
    @(posedge clk);
    cfg_bank <= b[2:0];
    cfg_sel <= s[1:0];
    repeat (2) @(posedge clk);
    #1 rv = cfg_rdata;
  endtask : rd

  // lane model, bit0 is the top byte
  function automatic logic [3:0] lanes(int sz, int pw, int a, int r, int m);
    logic [3:0] v;
    if (r != 0 && m == 0) return 4'hF;
    if (pw == 1) v = 4'h1;
    else if (pw > 1) v = (sz == 1) ? 4'h1 << (a % 2) : 4'h3;
    else if (sz == 1) v = 4'h1 << a;
    else if (sz == 2) v = (a > 1) ? 4'hC : 4'h3;
    else v = 4'hF;
    return ~v;
  endfunction : lanes

  // odd placements are left out: the lane table does not define them
  function automatic logic [31:0] fix(logic [31:0] a, int sz);
    if (sz == 1) return a;
    if (sz == 2) return a & ~32'h1;
    return a & ~32'h3;
  endfunction : fix

  task automatic bus(input logic [31:0] a, input xfer_size_e sz,
      input logic r, input logic cpu);
    int n, ack_at, hits;
    hits = $countones(~e_sel);
    @(posedge clk);
    cyc_start <= 1'b1;
    cyc_addr <= a;
    cyc_size <= sz;
    cyc_read <= r;
    cyc_cpu_space <= cpu;
    @(posedge clk);
    cyc_start <= 1'b0;
    #1;
    check(output_enable_n, 1);
    check({bank_select_n, boot_bank_select_n}, e_sel);
    check(lane_strobe_n, lanes(sz, e_pw, a[1:0], r, e_mode));
    check({cyc_ext_term, cyc_burst_ok, cyc_port_width},
      {hits != 1 || e_ack < 0, e_burst[0], e_pw[1:0]});
    @(negedge clk);
    #1;
    check(output_enable_n, !(r && hits > 0));
    ack_at = -1;
    for (n = 1; n < 60 && cyc_end !== 1'b1; n++) begin
      @(posedge clk);
      #1;
      if (auto_ack === 1'b1 && ack_at < 0) ack_at = n;
    end
    check(ack_at, e_ack);
    @(posedge clk);
    #1;
    check({bank_select_n, boot_bank_select_n, lane_strobe_n}, 12'hFFF);
    @(negedge clk);
    #1;
    check(output_enable_n, 1);
  endtask : bus

  initial begin
    #400000;
    fails++;
    end_sim();
  end

  initial begin
    int lo;
    {nrst, reset_input_n, cfg_wr, cyc_start, cyc_read, cyc_cpu_space} = 6'h0;
    {cfg_bank, cfg_sel, cfg_wdata, cyc_addr, strap_cfg} = '0;
    cyc_size = SZ_LONG;
    term_wait = 8'h01;
    void'($urandom(32'h73958475));
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    #1;
    check({bank_select_n, boot_bank_select_n, output_enable_n}, 9'h1FF);
    check({lane_strobe_n, boot_global}, 5'h1F);
    $display("reset test done");
    for (int k = 0; k < 4; k++) begin
      rv = $urandom();
      @(posedge clk);
      strap_cfg <= {rv[7] ^ k[0], k[1:0], 1'b0, rv[3] ^ k[1], 3'h0};
      reset_input_n <= 1'b0;
      repeat (3) @(posedge clk);
      reset_input_n <= 1'b1;
      repeat (3) @(posedge clk);
      rd(0, 2);
      check(rv, {18'h0, {4{strap_cfg[7]}}, 1'b0, strap_cfg[7], k[1:0],
        strap_cfg[3], 5'h0});
      check(boot_global, 1);
      e_sel = 8'hFE;
      e_pw = (k == 3) ? 2 : k;
      e_mode = strap_cfg[3];
      e_ack = strap_cfg[7] ? 16 : -1;
      term_wait = strap_cfg[7] ? 8'd17 : 8'd1;
      bus(fix($urandom(), k), xfer_size_e'(k), !k[1], 1'b0);
    end
    $display("boot strap test done");
    wr(0, 1, 32'h1);
    #1 check(boot_global, 0);
    wr(1, 0, 32'h1000_0000);
    wr(1, 1, 32'h1);
    for (int w = 0; w < 3; w++) begin
      for (int m = 0; m < 2; m++) begin
        wr(1, 2, (w << 6) | (m << 5));
        e_sel = 8'hFD;
        e_pw = w;
        e_mode = m;
        e_ack = -1;
        for (int s = 0; s < 32; s++) begin
          rv = $urandom();
          lo = (s / 2) % 4;
          term_wait = 8'($urandom_range(3));
          bus(fix({16'h1000, rv[15:2], lo[1:0]}, s / 8),
            xfer_size_e'(s / 8), s % 2, rv[16]);
        end
      end
    end
    $display("lane table test done");
    e_sel = 8'hFF;
    e_pw = 0;
    e_mode = 0;
    bus(32'h2000_0040, SZ_BYTE, 1'b1, 1'b0);
    bus(32'h2000_0041, SZ_BYTE, 1'b0, 1'b0);
    wr(1, 1, 32'h41);
    bus(32'h1000_0000, SZ_LONG, 1'b1, 1'b1);
    {e_sel, e_pw, e_mode} = {8'hFD, 32'd2, 32'd1};
    bus(32'h1000_0000, SZ_LONG, 1'b1, 1'b0);
    $display("no match and processor space test done");
    // read burst only, zero waits with internal acknowledge
    wr(1, 2, 32'h110);
    e_pw = 0;
    e_mode = 0;
    e_burst = 1;
    e_ack = 1;
    term_wait = 8'h02;
    bus(32'h1000_0010, SZ_LINE, 1'b1, 1'b0);
    e_burst = 0;
    bus(32'h1000_0020, SZ_LINE, 1'b0, 1'b0);
    $display("burst and quick acknowledge test done");
    wr(2, 0, 32'h1000_0000);
    wr(2, 1, 32'h1);
    {e_sel, e_pw, e_mode} = {8'hF9, 32'd0, 32'd0};
    e_ack = -1;
    bus(32'h1000_0002, SZ_WORD, 1'b0, 1'b0);
    rd(1, 0);
    check(rv, 32'h1000_0000);
    wr(1, 3, $urandom());
    rd(1, 3);
    check(rv, 32'h0);
    $display("multiple match and register test done");
    end_sim();
  end
endmodule : chip_select_byte_lane_decode_test
